// file: logic/sbaf_top.sv
// Contract
// - never drive acknowledge in the slot after the START byte
// - repeated START after START byte restarts byte reception, discarding it
// - poll data line slowly until a low is seen, then sample fast
// - never acknowledge legacy address 0000 001x and ignore what follows
// - after STOP ending legacy traffic, return idle ready for new START
// - slave may stretch clock low while busy, releasing when done
// - on management bus no clock low beyond 35 ms; reset bus logic
// - in unidirectional mode no device identification read-back
// - any START or repeated START resets bus logic to expect address
`timescale 1ns/1ps
`default_nettype none
`include "sbaf_defs.svh"

module sbaf_top
  import sbaf_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SBAF_TIMEOUT_MS * 1000 * `SBAF_CLK_MHZ,
  parameter int unsigned POLL_DIV    = `SBAF_POLL_DIV
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // bus pins, open drain
  input  wire sbaf_pins_t bus_in,
  output sbaf_pins_t      bus_out,
  output sbaf_pins_t      bus_oe,
  // configuration
  input  wire logic [6:0] own_addr,
  input  wire logic       smbus_en,
  input  wire logic       ufm_en,
  input  wire logic       poll_en,
  input  wire logic       busy_req,
  // events and data
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            selected,
  output logic            start_byte_seen,
  output logic            devid_req,
  output logic            legacy_data_line_gate,
  output logic            timeout_err
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int PW = (POLL_DIV > 1) ? $clog2(POLL_DIV) : 1;

  sbaf_pins_t  pins_s;
  sbaf_state_t state;
  logic        scl_view;
  logic        scl_q;
  logic        sda_view;
  logic        sda_q;
  logic        fast_sample;
  logic [PW-1:0] poll_cnt;
  logic [TW-1:0] low_cnt;
  logic [7:0]  shreg;
  logic [3:0]  bit_cnt;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        to_hit;
  logic        poll_tick;
  logic [7:0]  next_byte;

  sbaf_sync #(
    .W       (2),
    .RST_VAL (`SBAF_LINE_IDLE)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (bus_in),
    .dout    (pins_s)
  );

  assign scl_rise  = scl_view & ~scl_q;
  assign scl_fall  = ~scl_view & scl_q;
  assign start_det = scl_view & scl_q & sda_q & ~sda_view;
  assign stop_det  = scl_view & scl_q & ~sda_q & sda_view;
  assign poll_tick = (poll_cnt == PW'(POLL_DIV - 1));
  assign to_hit    = smbus_en & (low_cnt == TW'(TIMEOUT_CYC - 1));
  assign next_byte = {shreg[6:0], sda_view};

  // open drain: the driven level is always low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_out <= '0;
    end else begin
      bus_out <= '0;
    end
  end

  // line views; while polling, the data line is looked at only once per tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_view <= `SBAF_LINE_IDLE;
      scl_q    <= `SBAF_LINE_IDLE;
      sda_view <= `SBAF_LINE_IDLE;
      sda_q    <= `SBAF_LINE_IDLE;
    end else begin
      scl_view <= pins_s.scl;
      scl_q    <= scl_view;
      sda_q    <= sda_view;
      if (fast_sample || !poll_en || poll_tick) begin
        sda_view <= pins_s.sda;
      end
    end
  end

  // a start seen at the slow rate may be missed; the start byte zeros
  // give the slow sampler time to catch up before the repeated start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      poll_cnt    <= '0;
      fast_sample <= 1'b0;
    end else begin
      poll_cnt <= poll_tick ? '0 : poll_cnt + PW'(1);
      if (stop_det || to_hit) begin
        fast_sample <= 1'b0;
      end else if (poll_en && !sda_view) begin
        fast_sample <= 1'b1;
      end
    end
  end

  // continuous clock-low time; the master keeps the clock fast enough
  // that a healthy transfer never reaches the limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt     <= '0;
      timeout_err <= 1'b0;
    end else begin
      timeout_err <= to_hit;
      if (scl_view || !smbus_en || to_hit) begin
        low_cnt <= '0;
      end else begin
        low_cnt <= low_cnt + TW'(1);
      end
    end
  end

  // receiver sequence; it also owns the clock stretch so that the pin
  // enable pair has a single writer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state                 <= ST_IDLE;
      bus_oe.scl            <= 1'b0;
      shreg                 <= '0;
      bit_cnt               <= '0;
      bus_oe.sda            <= 1'b0;
      selected              <= 1'b0;
      rx_data               <= '0;
      rx_valid              <= 1'b0;
      start_byte_seen       <= 1'b0;
      devid_req             <= 1'b0;
      legacy_data_line_gate <= 1'b0;
    end else begin
      rx_valid        <= 1'b0;
      start_byte_seen <= 1'b0;
      devid_req       <= 1'b0;
      // stretch only after an acknowledged byte, and never grab a high clock
      bus_oe.scl      <= selected && state == ST_DATA && bit_cnt == '0 && busy_req
                         && (bus_oe.scl || !scl_view) && !to_hit && !start_det;
      if (to_hit) begin
        state                 <= ST_IDLE;
        bus_oe.sda            <= 1'b0;
        selected              <= 1'b0;
        legacy_data_line_gate <= 1'b0;
      end else if (start_det) begin
        state                 <= ST_ADDR;
        bit_cnt               <= '0;
        bus_oe.sda            <= 1'b0;
        selected              <= 1'b0;
        legacy_data_line_gate <= 1'b0;
      end else if (stop_det) begin
        state                 <= ST_IDLE;
        bus_oe.sda            <= 1'b0;
        selected              <= 1'b0;
        legacy_data_line_gate <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_DATA: begin
            if (scl_rise && bit_cnt != `SBAF_BYTE_BITS) begin
              shreg   <= next_byte;
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `SBAF_BYTE_BITS) begin
              state   <= ST_ACK;
              bit_cnt <= '0;
              if (state == ST_DATA) begin
                rx_data    <= shreg;
                rx_valid   <= 1'b1;
                bus_oe.sda <= 1'b1;
              end else if (shreg == `SBAF_START_BYTE) begin
                start_byte_seen <= 1'b1;
              end else if (shreg[7:1] == `SBAF_LEGACY_ADDR) begin
                legacy_data_line_gate <= 1'b1;
              end else if (shreg[7:1] == `SBAF_DEVID_ADDR) begin
                bus_oe.sda <= !ufm_en;
                devid_req  <= !ufm_en;
              end else if (shreg[7:1] == own_addr && !shreg[0]) begin
                bus_oe.sda <= 1'b1;
                selected   <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bus_oe.sda <= 1'b0;
              state      <= selected ? ST_DATA : ST_SKIP;
            end
          end
          ST_SKIP: begin
            state <= ST_SKIP;
          end
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  start_byte_nack_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_byte_seen |-> !bus_oe.sda ##1 !bus_oe.sda)
    else $error("acknowledge driven after start byte");

  legacy_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(legacy_data_line_gate) |-> !bus_oe.sda && !selected)
    else $error("legacy address acknowledged");

  restart_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_det && !to_hit |=> state == ST_ADDR && bit_cnt == '0 && !selected)
    else $error("start did not restart address reception");

  start_byte_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_byte_seen ##[1:200] (start_det && !to_hit) |=> state == ST_ADDR && bit_cnt == '0 && !rx_valid)
    else $error("start byte passed on");

  stop_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    stop_det && !start_det && !to_hit |=> state == ST_IDLE && !legacy_data_line_gate)
    else $error("stop did not return to idle");

  timeout_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    to_hit |=> timeout_err && !bus_oe.scl && !bus_oe.sda && state == ST_IDLE)
    else $error("timeout did not release lines");

  stretch_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    bus_oe.scl && !busy_req |=> !bus_oe.scl)
    else $error("clock held after busy ended");

  devid_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    devid_req |-> !$past(ufm_en))
    else $error("device id served in unidirectional mode");

  poll_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
    poll_en && !fast_sample && !poll_tick |=> $stable(sda_view))
    else $error("data line sampled fast while polling");

  low_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
    smbus_en && low_cnt == TW'(TIMEOUT_CYC - 1) |=> low_cnt == '0)
    else $error("clock low counter passed limit");

endmodule

`default_nettype wire

// file: include/sbaf_defs.svh
`ifndef SBAF_DEFS_SVH
`define SBAF_DEFS_SVH

// fixed codes and byte length on the wire
`define SBAF_START_BYTE   8'h01
`define SBAF_LEGACY_ADDR  7'h01
`define SBAF_DEVID_ADDR   7'h7c
`define SBAF_BYTE_BITS    4'h8

// line level while no one drives
`define SBAF_LINE_IDLE    1'b1

// timing
`define SBAF_CLK_MHZ      125
`define SBAF_TIMEOUT_MS   35
`define SBAF_POLL_DIV     16

`endif

// file: include/sbaf_pkg.sv
package sbaf_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
  } sbaf_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_DATA,
    ST_SKIP
  } sbaf_state_t;

endpackage

// file: logic/sbaf_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sbaf_sync #(
  parameter int       W       = 2,
  parameter logic     RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // raw and synchronised levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // meta is read by dout only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= {W{RST_VAL}};
      dout <= {W{RST_VAL}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

`default_nettype wire

// file: test/sbaf_master.sv
`timescale 1ns/1ps
`default_nettype none

module sbaf_master (
  // wired line levels
  input  wire logic scl_line,
  input  wire logic sda_line,
  // open-drain drive, 0 pulls low
  output logic      m_scl,
  output logic      m_sda
);
  // clock stands high outside frames
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end

  // quarter of a 125 ns bit; pins move by nonblocking update so that a
  // change landing on a clock edge never races the synchroniser
  localparam realtime QTR = 31.25;

  // sda moves only while scl is low; the bit time is 125 ns unless the clock is stretched, so
  // the 62.5 ns low phases stay far inside the 1600 ns bench timeout
  task automatic bit_io(input logic b, output logic s);
    m_sda <= b;
    #QTR;
    m_scl <= 1'b1;
    // a stretched clock holds the master here
    wait (scl_line);
    #QTR;
    s = sda_line;
    #QTR;
    m_scl <= 1'b0;
    #QTR;
  endtask

  task automatic start;
    m_sda <= 1'b1;
    #QTR;
    m_scl <= 1'b1;
    #(2 * QTR);
    m_sda <= 1'b0;
    #(2 * QTR);
    m_scl <= 1'b0;
    #QTR;
  endtask

  task automatic stop;
    m_sda <= 1'b0;
    #QTR;
    m_scl <= 1'b1;
    #(2 * QTR);
    m_sda <= 1'b1;
    #(2 * QTR);
  endtask

  // msb first, then a released ninth slot; nack is the line level there
  task automatic xfer(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, nack);
  endtask
endmodule

`default_nettype wire

// file: test/sbaf_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbaf_defs.svh"

module sbaf_top_test
  import sbaf_pkg::*;
;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  sbaf_pins_t bus_in;
  sbaf_pins_t bus_out;
  sbaf_pins_t bus_oe;
  logic [6:0] own_addr = 7'h2a;
  logic       smbus_en = 1'b0;
  logic       ufm_en = 1'b0;
  logic       poll_en = 1'b0;
  logic       busy_req = 1'b0;
  logic [7:0] rx_data;
  logic       rx_valid, selected, start_byte_seen, devid_req, legacy_data_line_gate, timeout_err;
  logic       m_scl, m_sda, ak;
  logic [3:0] seen = 4'h0;
  logic       clr = 1'b0;
  int         fails = 0;
  int         check_count = 0;
  int         cyc = 0;

  always #4 clk = ~clk;
  // pulled-up open-drain lines
  assign bus_in = {m_scl & ~bus_oe.scl, m_sda & ~bus_oe.sda};

  sbaf_top #(.TIMEOUT_CYC(200), .POLL_DIV(4)) i_sbaf_top (
    .clk(clk), .sys_rst(sys_rst), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .own_addr(own_addr), .smbus_en(smbus_en), .ufm_en(ufm_en), .poll_en(poll_en),
    .busy_req(busy_req), .rx_data(rx_data), .rx_valid(rx_valid), .selected(selected),
    .start_byte_seen(start_byte_seen), .devid_req(devid_req),
    .legacy_data_line_gate(legacy_data_line_gate), .timeout_err(timeout_err));

  sbaf_master i_sbaf_master (.scl_line(bus_in.scl), .sda_line(bus_in.sda), .m_scl(m_scl), .m_sda(m_sda));

  // pulses are one cycle wide, so they are held until cleared
  always @(posedge clk) begin
    if (clr) begin
      seen <= 4'h0;
    end else begin
      seen <= seen | {timeout_err, devid_req, start_byte_seen, rx_valid};
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic clear;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
  endtask

  task automatic send(input logic [7:0] b, input logic exp_nack);
    i_sbaf_master.xfer(b, ak);
    chk(8'(ak), 8'(exp_nack));
  endtask

  task automatic t_write;
    clear;
    i_sbaf_master.start;
    send({own_addr, 1'b0}, 1'b0);
    chk(8'(selected), 8'h1);
    send(8'ha5, 1'b0);
    i_sbaf_master.stop;
    chk(rx_data, 8'ha5);
    chk(8'(seen[0]), 8'h1);
    chk(8'(selected), 8'h0);
  endtask

  task automatic t_start_byte;
    @(posedge clk) poll_en <= 1'b1;
    clear;
    i_sbaf_master.start;
    send(`SBAF_START_BYTE, 1'b1);
    chk(8'(seen[1]), 8'h1);
    i_sbaf_master.start;
    send({own_addr, 1'b0}, 1'b0);
    send(8'h3c, 1'b0);
    i_sbaf_master.stop;
    chk(rx_data, 8'h3c);
    @(posedge clk) poll_en <= 1'b0;
  endtask

  task automatic t_legacy;
    for (int k = 0; k < 2; k++) begin
      clear;
      i_sbaf_master.start;
      send({`SBAF_LEGACY_ADDR, 1'(k)}, 1'b1);
      chk(8'(legacy_data_line_gate), 8'h1);
      send({own_addr, 1'b0}, 1'b1);
      chk(8'(seen[0]), 8'h0);
      i_sbaf_master.stop;
      chk(8'(legacy_data_line_gate), 8'h0);
    end
    t_write;
  endtask

  task automatic t_devid;
    @(posedge clk) ufm_en <= 1'b1;
    clear;
    i_sbaf_master.start;
    send({`SBAF_DEVID_ADDR, 1'b0}, 1'b1);
    chk(8'(seen[2]), 8'h0);
    i_sbaf_master.stop;
    @(posedge clk) ufm_en <= 1'b0;
    i_sbaf_master.start;
    send({`SBAF_DEVID_ADDR, 1'b0}, 1'b0);
    chk(8'(seen[2]), 8'h1);
    i_sbaf_master.stop;
  endtask

  task automatic t_stretch;
    @(posedge clk) busy_req <= 1'b1;
    i_sbaf_master.start;
    send({own_addr, 1'b0}, 1'b0);
    fork
      i_sbaf_master.xfer(8'h5a, ak);
      begin
        repeat (40) @(posedge clk);
        chk(8'(bus_oe.scl), 8'h1);
        chk(8'(bus_out), 8'h0);
        busy_req <= 1'b0;
      end
    join
    chk(8'(ak), 8'h0);
    i_sbaf_master.stop;
    chk(rx_data, 8'h5a);
  endtask

  // the stuck byte must never reach the receiver
  task automatic t_timeout;
    @(posedge clk) smbus_en <= 1'b1;
    busy_req <= 1'b1;
    clear;
    i_sbaf_master.start;
    send({own_addr, 1'b0}, 1'b0);
    fork
      i_sbaf_master.xfer(8'h77, ak);
      begin
        repeat (260) @(posedge clk);
        chk(8'(seen[3]), 8'h1);
        chk(8'(bus_oe), 8'h0);
        chk(8'(selected), 8'h0);
      end
    join
    chk(8'(ak), 8'h1);
    i_sbaf_master.stop;
    chk(rx_data, 8'h5a);
  endtask

  task automatic results;
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_write;
    t_start_byte;
    t_legacy;
    t_devid;
    t_stretch;
    t_timeout;
    results;
  end
endmodule

`default_nettype wire
